// file: dcpa_event_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcpa_regs.svh"

// Summary of operation
// - Mode select high 0, low 1 gives independent PWM and accumulator units.
// - Mode select high 1, low 0 lets accumulator count PWM periods.
// - In mode 1 both 8-bit counters count from their own selectors.
// - One shared scaled rate exists; each counter picks it or undivided clock.
// - PWM clock: system clock, scaled clock, first event input, or gated clock.
// - Period match resets output, clears PWM counter, raises period event.
// - Duty match sets output state to one, held until period match.
// - Duty percent equals 100 times period minus duty, over period plus one.
// - Polarity 0: period match gives zero, duty match one; 1 inverts.
// - PWM unit acts as plain accumulator with output off, duty ignored.
// - Accumulator clock in mode 1 comes from the second input selector.
// - Accumulator clears on clear compare match; any 8-bit value allowed.
// - Accumulator event compare match raises the accumulator event.
// - First input edge clocking: rising, falling, or both edges.
// - Second input edge clocking: rising or falling edge only.
// - Active gating level stops time-base counting while it is present.
// - Time-base offers divide 1 to 128; second selector may take undivided.
// - Event output drives pin only while output enable is one.
// - In mode 2 accumulator increments once per PWM period match.
// - In mode 0 second input active edge or level clears accumulator.

module dcpa_event_counter #(
  parameter int CNT_WIDTH = 8
) (
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  input  wire logic                    mode_select_high,
  input  wire logic                    mode_select_low,
  input  wire logic [2:0]              rate_select,
  input  wire dcpa_pkg::dcpa_sel_cfg_t first_input_selector,
  input  wire dcpa_pkg::dcpa_sel_cfg_t second_input_selector,
  input  wire logic                    clear_on_level,
  input  wire dcpa_pkg::dcpa_cmp_t     pwm_compare,
  input  wire dcpa_pkg::dcpa_cmp_t     accumulator_compare,
  input  wire logic                    output_enable_bit,
  input  wire logic                    output_polarity_bit,
  input  wire logic                    first_event_input,
  input  wire logic                    second_event_input,
  input  wire logic                    pwm_event_clear,
  input  wire logic                    accumulator_event_clear,
  input  wire logic                    pwm_event_enable,
  input  wire logic                    accumulator_event_enable,
  output logic [7:0]                   pwm_counter,
  output logic [7:0]                   accumulator_counter,
  output logic                         event_output,
  output logic                         event_output_oe,
  output logic                         pwm_period_event,
  output logic                         accumulator_event,
  output logic                         pwm_event_flag,
  output logic                         accumulator_event_flag,
  output logic                         pwm_irq,
  output logic                         accumulator_irq
);

  // --------------------------------------------------------------------------
  // Elaboration checks.
  // --------------------------------------------------------------------------
  // The compare registers and counters are fixed at eight bits.
  if (CNT_WIDTH != 8) begin : g_bad_width
    $error("dcpa_event_counter supports only an 8-bit counter width");
  end

  // --------------------------------------------------------------------------
  // Mode decode.
  // --------------------------------------------------------------------------
  dcpa_pkg::dcpa_mode_t mode;
  assign mode = dcpa_pkg::dcpa_mode_t'({mode_select_high, mode_select_low});

  wire mode_phase  = (mode == dcpa_pkg::DCPA_PHASE);
  wire mode_indep  = (mode == dcpa_pkg::DCPA_INDEP);
  wire mode_period = (mode == dcpa_pkg::DCPA_PERIOD);

  // --------------------------------------------------------------------------
  // Shared time-base.
  // --------------------------------------------------------------------------
  logic [`DCPA_TB_WIDTH-1:0] tb_reg;
  logic [`DCPA_TB_WIDTH-1:0] tb_next;
  logic                      scaled_tick;

  // The time-base runs free; one rate is chosen for both units at once.
  assign tb_next = tb_reg + `DCPA_TB_WIDTH'(1);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tb_reg <= '0;
    end else begin
      tb_reg <= tb_next;
    end
  end

  // Divide by 2^rate: tick when the low rate bits of the count roll over.
  function automatic logic rate_tick(input logic [2:0] rate,
                                     input logic [`DCPA_TB_WIDTH-1:0] tb);
    logic [`DCPA_TB_WIDTH-1:0] mask;
    mask = `DCPA_TB_WIDTH'((8'h01 << rate) - 8'h01);
    rate_tick = ((tb & mask) == mask);
  endfunction

  assign scaled_tick = rate_tick(rate_select, tb_reg);

  // --------------------------------------------------------------------------
  // Input selectors.
  // --------------------------------------------------------------------------
  logic first_tick;
  logic second_tick;
  logic second_edge;
  logic second_level;

  // First selector supports both-edge counting.
  dcpa_input_sel #(
    .ALLOW_BOTH (1'b1)
  ) u_first (
    .mclk         (mclk),
    .nrst         (nrst),
    .cfg          (first_input_selector),
    .scaled_tick  (scaled_tick),
    .pin_in       (first_event_input),
    .count_tick   (first_tick),
    .active_edge  (),
    .active_level ()
  );

  // Second selector is restricted to a single edge.
  dcpa_input_sel #(
    .ALLOW_BOTH (1'b0)
  ) u_second (
    .mclk         (mclk),
    .nrst         (nrst),
    .cfg          (second_input_selector),
    .scaled_tick  (scaled_tick),
    .pin_in       (second_event_input),
    .count_tick   (second_tick),
    .active_edge  (second_edge),
    .active_level (second_level)
  );

  // --------------------------------------------------------------------------
  // PWM unit.
  // --------------------------------------------------------------------------
  logic [7:0] pwm_cnt_reg;
  logic [7:0] pwm_cnt_next;
  logic       out_state_reg;
  logic       out_state_next;
  logic       period_match;
  logic       duty_match;

  // A match acts only on a counting tick so a stalled counter fires once.
  assign period_match = first_tick && (pwm_cnt_reg == pwm_compare.cmp_a);
  assign duty_match   = first_tick && (pwm_cnt_reg == pwm_compare.cmp_b);

  // Period match wins over duty match when both compares are equal.
  assign pwm_cnt_next = period_match ? `DCPA_CNT_RESET :
                        first_tick   ? pwm_cnt_reg + 8'h01 :
                                       pwm_cnt_reg;

  // Raw state is 0 after period and 1 after duty, giving
  // 100*(period-duty)/(period+1) percent high time at polarity 0.
  assign out_state_next = period_match ? 1'b0 :
                          duty_match   ? 1'b1 :
                                         out_state_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pwm_cnt_reg   <= `DCPA_CNT_RESET;
      out_state_reg <= 1'b0;
    end else begin
      pwm_cnt_reg   <= pwm_cnt_next;
      out_state_reg <= out_state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Accumulator unit.
  // --------------------------------------------------------------------------
  logic [7:0] acc_cnt_reg;
  logic [7:0] acc_cnt_next;
  logic       acc_tick;
  logic       acc_ext_clear;
  logic       acc_clear_match;
  logic       acc_event_match;

  // Mode 2 takes the period match; mode 0 shares the first selector.
  assign acc_tick = mode_period ? period_match :
                    mode_indep  ? second_tick :
                    mode_phase  ? first_tick :
                                  second_tick;

  // In mode 0 the second input only clears, by edge or by level.
  assign acc_ext_clear = mode_phase &&
                         (clear_on_level ? second_level : second_edge);

  assign acc_clear_match = acc_tick && (acc_cnt_reg == accumulator_compare.cmp_a);
  assign acc_event_match = acc_tick && (acc_cnt_reg == accumulator_compare.cmp_b);

  assign acc_cnt_next = acc_ext_clear   ? `DCPA_CNT_RESET :
                        acc_clear_match ? `DCPA_CNT_RESET :
                        acc_tick        ? acc_cnt_reg + 8'h01 :
                                          acc_cnt_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_cnt_reg <= `DCPA_CNT_RESET;
    end else begin
      acc_cnt_reg <= acc_cnt_next;
    end
  end

  // --------------------------------------------------------------------------
  // Event pulses and sticky flags.
  // --------------------------------------------------------------------------
  logic pwm_evt_reg;
  logic acc_evt_reg;
  logic pwm_flag_reg;
  logic acc_flag_reg;

  // Set wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pwm_evt_reg  <= 1'b0;
      acc_evt_reg  <= 1'b0;
      pwm_flag_reg <= 1'b0;
      acc_flag_reg <= 1'b0;
    end else begin
      pwm_evt_reg  <= period_match;
      acc_evt_reg  <= acc_event_match;
      pwm_flag_reg <= period_match | (pwm_flag_reg & ~pwm_event_clear);
      acc_flag_reg <= acc_event_match | (acc_flag_reg & ~accumulator_event_clear);
    end
  end

  // --------------------------------------------------------------------------
  // Output unit.
  // --------------------------------------------------------------------------
  logic evo_reg;

  // With the enable off the pin is released for general I/O, which also
  // lets the PWM unit serve as a plain accumulator.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      evo_reg <= 1'b0;
    end else begin
      evo_reg <= output_enable_bit & (out_state_next ^ output_polarity_bit);
    end
  end

  assign event_output    = evo_reg;
  assign event_output_oe = output_enable_bit;

  assign pwm_counter            = pwm_cnt_reg;
  assign accumulator_counter    = acc_cnt_reg;
  assign pwm_period_event       = pwm_evt_reg;
  assign accumulator_event      = acc_evt_reg;
  assign pwm_event_flag         = pwm_flag_reg;
  assign accumulator_event_flag = acc_flag_reg;
  assign pwm_irq                = pwm_flag_reg & pwm_event_enable;
  assign accumulator_irq        = acc_flag_reg & accumulator_event_enable;

endmodule

`default_nettype wire

// file: dcpa_event_counter_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker for the event counter.
// ----
module dcpa_event_counter_monitor (
  input wire logic                mclk,
  input wire logic                nrst,
  input wire logic                mode_select_high,
  input wire logic                mode_select_low,
  input wire dcpa_pkg::dcpa_cmp_t pwm_compare,
  input wire dcpa_pkg::dcpa_cmp_t accumulator_compare,
  input wire logic                output_enable_bit,
  input wire logic                output_polarity_bit,
  input wire logic                pwm_event_clear,
  input wire logic                pwm_event_enable,
  input wire logic                accumulator_event_enable,
  input wire logic [7:0]          pwm_counter,
  input wire logic [7:0]          accumulator_counter,
  input wire logic                event_output,
  input wire logic                event_output_oe,
  input wire logic                pwm_period_event,
  input wire logic                accumulator_event,
  input wire logic                pwm_event_flag,
  input wire logic                accumulator_event_flag,
  input wire logic                pwm_irq,
  input wire logic                accumulator_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Mode 0 clears the accumulator from the second input, so only modes 1 and 2 are judged here.
  wire logic md12 = mode_select_high ^ mode_select_low;
  wire logic md2  = mode_select_high & ~mode_select_low;
  // A period wrap: the count sat on the period value and fell to zero.
  sequence pwm_wrap;
    md12 && $past(md12) && $past(pwm_counter) == $past(pwm_compare.cmp_a) &&
      $past(pwm_counter) != 8'h00 && pwm_counter == 8'h00;
  endsequence
  chk_pwm_step: assert property (
    md12 && $past(md12) && pwm_counter != $past(pwm_counter) |->
    pwm_counter == $past(pwm_counter) + 8'h01 ||
    pwm_counter == 8'h00 && $past(pwm_counter) == $past(pwm_compare.cmp_a))
    else $error("pwm counter moved other than by one or a period clear");
  chk_acc_step: assert property (
    md12 && $past(md12) && accumulator_counter != $past(accumulator_counter) |->
    accumulator_counter == $past(accumulator_counter) + 8'h01 || accumulator_counter == 8'h00 &&
    $past(accumulator_counter) == $past(accumulator_compare.cmp_a))
    else $error("accumulator moved other than by one or a clear");
  chk_period_pulse: assert property (pwm_wrap |-> pwm_period_event)
    else $error("period wrap without period event");
  chk_period_level: assert property (
    pwm_wrap |-> event_output == ($past(output_enable_bit) & $past(output_polarity_bit)))
    else $error("event output level wrong after period match");
  chk_period_count: assert property (
    pwm_wrap ##0 (md2 && $past(md2) &&
    $past(accumulator_counter) != $past(accumulator_compare.cmp_a)) |->
    accumulator_counter == $past(accumulator_counter) + 8'h01)
    else $error("period wrap did not advance accumulator");
  chk_acc_event: assert property (
    accumulator_event |-> $past(accumulator_counter) == $past(accumulator_compare.cmp_b))
    else $error("accumulator event without compare match");
  chk_flag_set: assert property (
    (pwm_period_event |-> pwm_event_flag) and (accumulator_event |-> accumulator_event_flag))
    else $error("event without its flag");
  chk_flag_hold: assert property (pwm_event_flag && !pwm_event_clear |=> pwm_event_flag)
    else $error("flag dropped without clear");
  chk_irq_gate: assert property (
    pwm_irq == (pwm_event_flag & pwm_event_enable) &&
    accumulator_irq == (accumulator_event_flag & accumulator_event_enable))
    else $error("request not flag and enable");
  chk_out_off: assert property (
    !$past(output_enable_bit) && pwm_counter != $past(pwm_counter) |-> !event_output)
    else $error("event output driven while disabled");
  chk_oe_follow: assert property (event_output_oe == output_enable_bit)
    else $error("output enable does not follow control bit");
  cov_wrap: cover property (pwm_wrap);
  cov_acc: cover property (accumulator_event);
  cov_mode2: cover property (pwm_wrap ##0 md2);
endmodule
bind dcpa_event_counter dcpa_event_counter_monitor u_dcpa_event_counter_monitor (.*);
`default_nettype wire

// file: dcpa_input_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcpa_regs.svh"

module dcpa_input_sel #(
  parameter bit ALLOW_BOTH = 1'b1
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire dcpa_pkg::dcpa_sel_cfg_t cfg,
  input  wire logic                   scaled_tick,
  input  wire logic                   pin_in,
  output logic                        count_tick,
  output logic                        active_edge,
  output logic                        active_level
);

  // --------------------------------------------------------------------------
  // Pin synchroniser and edge history.
  // --------------------------------------------------------------------------
  logic [1:0] sync_reg;
  logic       prev_reg;

  // Two stages before any logic looks at the pin; prev holds the old level.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_reg <= `DCPA_SYNC_RESET;
      prev_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[0], pin_in};
      prev_reg <= sync_reg[1];
    end
  end

  // --------------------------------------------------------------------------
  // Edge and source decode.
  // --------------------------------------------------------------------------
  wire pin_s   = sync_reg[1];
  wire rise    = pin_s & ~prev_reg;
  wire fall    = ~pin_s & prev_reg;
  wire sel_r   = (cfg.edge_sel == `DCPA_EDGE_RISE);
  wire sel_f   = (cfg.edge_sel == `DCPA_EDGE_FALL);
  // Both-edge counting exists only where the unit supports it.
  wire sel_b   = ALLOW_BOTH && (cfg.edge_sel == `DCPA_EDGE_BOTH);
  wire gated   = (pin_s == cfg.gate_level);

  assign active_edge  = (rise & sel_r) | (fall & sel_f) | ((rise | fall) & sel_b);
  assign active_level = gated;

  // Gating holds the time-base tick off while the active level stands.
  always_comb begin
    unique case (cfg.source)
      `DCPA_SRC_SYSCLK: count_tick = 1'b1;
      `DCPA_SRC_SCALED: count_tick = scaled_tick;
      `DCPA_SRC_EXT:    count_tick = active_edge;
      `DCPA_SRC_GATED:  count_tick = scaled_tick & ~gated;
    endcase
  end

endmodule

`default_nettype wire

// file: dcpa_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// External pin source.
// ----
module dcpa_pin_source (
  input  wire logic mclk,
  output var logic  first_event_input,
  output var logic  second_event_input
);
  // Both pins rest low when no edges are requested.
  initial begin
    first_event_input = 1'b0;
    second_event_input = 1'b0;
  end
  // Each level stands two cycles, so the two-flop synchroniser never misses one.
  task automatic pulse(input bit sel, input int n);
    repeat (2 * n) begin
      @(posedge mclk);
      #5;
      if (sel) begin
        second_event_input = ~second_event_input;
      end else begin
        first_event_input = ~first_event_input;
      end
      @(posedge mclk);
    end
  endtask
  // Holds the first pin at a steady level, as a gating signal would.
  task automatic hold(input logic level);
    @(posedge mclk);
    #5;
    first_event_input = level;
  endtask
endmodule
`default_nettype wire

// file: dcpa_pkg.sv
package dcpa_pkg;

  // Mode selection as an enumeration for state-like decoding.
  typedef enum logic [1:0] {
    DCPA_PHASE    = 2'h0,
    DCPA_INDEP    = 2'h1,
    DCPA_PERIOD   = 2'h2,
    DCPA_PRESCALE = 2'h3
  } dcpa_mode_t;

  // Configuration of one input selector.
  typedef struct packed {
    logic [1:0] source;     // Clock source code.
    logic [1:0] edge_sel;   // Active edge when externally clocked.
    logic       gate_level; // Gating level that stops counting.
  } dcpa_sel_cfg_t;

  // Compare values of one unit.
  typedef struct packed {
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
  } dcpa_cmp_t;

endpackage

// file: dcpa_regs.svh
`ifndef DCPA_REGS_SVH
`define DCPA_REGS_SVH

// ----------------------------------------------------------------------------
// Mode codes {mode_select_high, mode_select_low}.
// ----------------------------------------------------------------------------
`define DCPA_MODE_PHASE     2'h0
`define DCPA_MODE_INDEP     2'h1
`define DCPA_MODE_PERIOD    2'h2
`define DCPA_MODE_PRESCALE  2'h3

// ----------------------------------------------------------------------------
// Input selector source codes.
// ----------------------------------------------------------------------------
`define DCPA_SRC_SYSCLK     2'h0
`define DCPA_SRC_SCALED     2'h1
`define DCPA_SRC_EXT        2'h2
`define DCPA_SRC_GATED      2'h3

// ----------------------------------------------------------------------------
// Edge select codes for external clocking.
// ----------------------------------------------------------------------------
`define DCPA_EDGE_RISE      2'h0
`define DCPA_EDGE_FALL      2'h1
`define DCPA_EDGE_BOTH      2'h2

// ----------------------------------------------------------------------------
// Time-base and reset values.
// ----------------------------------------------------------------------------
`define DCPA_TB_WIDTH       7
`define DCPA_CNT_RESET      8'h00
`define DCPA_CMP_RESET      8'h00
`define DCPA_SYNC_RESET     2'h0

`endif

// file: tb_dual_counter_pwm_accumulator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_counter_pwm_accumulator;
  logic                    mclk, nrst, mode_select_high, mode_select_low, clear_on_level;
  logic                    output_enable_bit, output_polarity_bit, pwm_event_enable;
  logic                    pwm_event_clear, accumulator_event_clear, accumulator_event_enable;
  logic                    first_event_input, second_event_input, event_output, event_output_oe;
  logic                    pwm_period_event, accumulator_event, pwm_event_flag, pwm_irq;
  logic                    accumulator_event_flag, accumulator_irq;
  logic [2:0]              rate_select;
  logic [7:0]              pwm_counter, accumulator_counter;
  dcpa_pkg::dcpa_sel_cfg_t first_input_selector, second_input_selector;
  dcpa_pkg::dcpa_cmp_t     pwm_compare, accumulator_compare;
  int                      num_errors = 0;
  int                      checks = 0;
  dcpa_event_counter u_dcpa_event_counter (.*);
  dcpa_pin_source u_dcpa_pin_source (.*);
  // ----
  // Clock, watchdog and shared tasks.
  // ----
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // The run needs some 1400 cycles; the 16000-cycle limit, over ten times that, means a hang.
  initial begin
    #800000;
    num_errors++;
    end_of_test;
  end
  task automatic end_of_test;
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Reset is asserted again before each scenario, so each starts from zero counts.
  task automatic setup(input logic [1:0] md, input logic [4:0] s1, input logic [4:0] s2);
    nrst = 1'b0;
    step(4);
    nrst = 1'b1;
    {mode_select_high, mode_select_low} = md;
    first_input_selector = s1;
    second_input_selector = s2;
    step(4);
  endtask
  // ----
  // Scenarios.
  // ----
  task automatic t_pwm_wave(input logic pol, input logic en, input int exp_high);
    int hi = 0;
    int i;
    output_polarity_bit = pol;
    output_enable_bit = en;
    pwm_event_enable = en;
    pwm_compare = {8'h05, 8'h01};
    setup(2'h1, 5'h00, 5'h00);
    repeat (6) begin
      if (event_output === 1'b1) hi++;
      step(1);
    end
    check("pwm high cycles", 8'(exp_high), 8'(hi));
    for (i = 0; i < 20 && pwm_period_event !== 1'b1; i++) step(1);
    check("pwm irq", {7'h00, en}, {7'h00, pwm_irq});
    pwm_event_clear = 1'b1;
    step(1);
    pwm_event_clear = 1'b0;
    check("pwm flag cleared", 8'h00, {7'h00, pwm_event_flag});
  endtask
  task automatic t_edges;
    logic [7:0] a1, a2;
    for (int e = 0; e < 3; e++) begin
      pwm_compare = {8'hFF, 8'h00};
      accumulator_compare = {8'hFF, 8'h00};
      setup(2'h1, {2'h2, 2'(e), 1'b0}, {2'h2, 2'(e), 1'b0});
      a1 = pwm_counter;
      a2 = accumulator_counter;
      u_dcpa_pin_source.pulse(1'b0, 3);
      u_dcpa_pin_source.pulse(1'b1, 3);
      step(6);
      check("first pin edges", (e == 2) ? 8'h06 : 8'h03, pwm_counter - a1);
      check("second pin edges", (e == 2) ? 8'h00 : 8'h03, accumulator_counter - a2);
    end
  endtask
  task automatic t_rates;
    logic [7:0] a1, a2;
    for (int r = 0; r < 8; r++) begin
      rate_select = 3'(r);
      setup(2'h1, 5'h08, 5'h00);
      a1 = pwm_counter;
      a2 = accumulator_counter;
      step(128);
      check("scaled count", 8'(128 >> r), pwm_counter - a1);
      check("undivided count", 8'h80, accumulator_counter - a2);
    end
    rate_select = 3'h0;
    first_input_selector = {2'h3, 2'h0, 1'b1};
    u_dcpa_pin_source.hold(1'b1);
    step(5);
    a1 = pwm_counter;
    step(20);
    check("gated stop", 8'h00, pwm_counter - a1);
    u_dcpa_pin_source.hold(1'b0);
    step(5);
    a1 = pwm_counter;
    step(20);
    check("gated run", 8'h14, pwm_counter - a1);
  endtask
  task automatic t_acc_wrap;
    int n = 1;
    int i;
    accumulator_compare = {8'h04, 8'h02};
    accumulator_event_enable = 1'b1;
    setup(2'h1, 5'h00, 5'h00);
    for (i = 0; i < 20 && accumulator_event !== 1'b1; i++) step(1);
    step(1);
    while (accumulator_event !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    check("accumulator event gap", 8'h05, 8'(n));
    check("accumulator irq", 8'h01, {7'h00, accumulator_irq});
  endtask
  task automatic t_modes;
    logic [7:0] a2;
    pwm_compare = {8'h03, 8'h01};
    accumulator_compare = {8'hFF, 8'h00};
    setup(2'h2, 5'h00, {2'h2, 2'h0, 1'b0});
    a2 = accumulator_counter;
    step(40);
    check("periods counted", 8'h0A, accumulator_counter - a2);
    setup(2'h0, 5'h00, {2'h2, 2'h0, 1'b0});
    step(20);
    u_dcpa_pin_source.pulse(1'b1, 1);
    step(1);
    check("mode0 clear", 8'h01, {7'h00, accumulator_counter < 8'h04});
    // A low pin matches gate level 0, so the level clear holds the count at zero.
    clear_on_level = 1'b1;
    step(3);
    check("mode0 level clear", 8'h00, accumulator_counter);
    clear_on_level = 1'b0;
  endtask
  // ----
  // Main sequence.
  // ----
  initial begin
    nrst = 1'b0;
    {mode_select_high, mode_select_low} = 2'h1;
    {clear_on_level, pwm_event_clear, accumulator_event_clear} = 3'h0;
    {output_enable_bit, output_polarity_bit, pwm_event_enable} = 3'h0;
    accumulator_event_enable = 1'b0;
    rate_select = 3'h0;
    first_input_selector = 5'h00;
    second_input_selector = 5'h00;
    pwm_compare = 16'h0000;
    accumulator_compare = 16'h0000;
    t_pwm_wave(1'b0, 1'b1, 4);
    t_pwm_wave(1'b1, 1'b1, 2);
    t_pwm_wave(1'b0, 1'b0, 0);
    t_edges();
    t_rates();
    t_acc_wrap();
    t_modes();
    output_enable_bit = 1'b0;
    step(1);
    check("output enable off", 8'h00, {7'h00, event_output_oe});
    end_of_test;
  end
endmodule
`default_nettype wire
